// File: verilog/pmb_pkg.sv
// Purpose: Shared constants and types for the packet to transaction bridge.
// Assumes: 8-bit stream symbols, 32-bit word-wide memory-mapped master.
// Notes:   Header fields arrive most significant byte first.
package pmb_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int BYTE_W  = 8;
  localparam int WORD_W  = 32;
  localparam int BE_W    = 4;
  localparam int SIZE_W  = 16;
  localparam int CNT_W   = 24;
  localparam int RESP_W  = BYTE_W + 2;
  localparam int BUF_DEPTH = 2;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CODE_WR_FIX = 8'h00;
  localparam logic [7:0] CODE_WR_INC = 8'h04;
  localparam logic [7:0] CODE_RD_FIX = 8'h10;
  localparam logic [7:0] CODE_RD_INC = 8'h14;
  localparam logic [7:0] CODE_IDLE   = 8'h7f;
  localparam logic [7:0] CODE_FLIP   = 8'h80;
  localparam logic [7:0] RSVD_BYTE   = 8'h00;

  // ****************************************************************
  // Header byte positions
  // ****************************************************************
  localparam logic [3:0] IDX_CODE     = 4'h0;
  localparam logic [3:0] IDX_SIZE_HI  = 4'h2;
  localparam logic [3:0] IDX_SIZE_LO  = 4'h3;
  localparam logic [3:0] IDX_ADDR_HI  = 4'h4;
  localparam logic [3:0] IDX_ADDR_LO  = 4'h7;
  localparam logic [3:0] HDR_LEN      = 4'h8;
  localparam logic [3:0] IDX_ONE      = 4'h1;

  // ****************************************************************
  // Word and response layout
  // ****************************************************************
  localparam logic [2:0]  WORD_BYTES = 3'h4;
  localparam logic [2:0]  LANE_LAST  = 3'h3;
  localparam logic [2:0]  LANE_ONE   = 3'h1;
  localparam logic [2:0]  RESP_CNT_HI = 3'h2;
  localparam logic [2:0]  RESP_CNT_MD = 3'h3;
  localparam logic [2:0]  RESP_LAST  = 3'h4;
  localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;
  localparam logic [4:0]  BE_ONE     = 5'h01;

  typedef enum logic [2:0] {
    S_HDR,
    S_WR,
    S_RD,
    S_RDOUT,
    S_RESP
  } pmb_state_t;

endpackage : pmb_pkg

// File: verilog/pmb_buf.sv
// Purpose: Two-entry buffer between response generator and stream source.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Head entry drives the outputs directly from flip-flops.
`timescale 1ns/1ps
module pmb_buf
  import pmb_pkg::*;
#(
  parameter int WIDTH = pmb_pkg::RESP_W
)(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0]     ent_q [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] v_q;
  logic                 pop;
  logic                 push;
  logic                 wr_idx;

  // Full only when the tail entry is taken
  assign in_ready  = !v_q[BUF_DEPTH-1];
  assign pop       = v_q[0] && out_ready;
  assign push      = in_valid && in_ready;
  assign wr_idx    = pop ? v_q[1] : v_q[0];
  assign out_valid = v_q[0];
  assign out_data  = ent_q[0];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      v_q <= '0;
      for (int i = 0; i < BUF_DEPTH; i++)
      begin
        ent_q[i] <= '0;
      end
    end
    else
    begin
      if (pop)
      begin
        v_q      <= {1'b0, v_q[1]};
        ent_q[0] <= ent_q[1];
      end
      if (push)
      begin
        v_q[wr_idx]   <= 1'b1;
        ent_q[wr_idx] <= in_data;
      end
    end
  end

endmodule : pmb_buf

// File: verilog/pmb_bridge.sv
// Purpose: Turns byte command packets into single-word master transactions.
// Assumes: Upstream source and slaves share sys_clk; read data valid in the cycle wait request drops.
// Notes:   One command at a time; responses leave through a two-entry buffer.
`timescale 1ns/1ps

module pmb_bridge
  import pmb_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        snk_valid,
  output logic                             snk_ready,
  input  wire logic [pmb_pkg::BYTE_W-1:0]  snk_data,
  input  wire logic                        snk_packet_start_marker,
  input  wire logic                        snk_packet_end_marker,
  output logic                             src_valid,
  input  wire logic                        src_ready,
  output logic [pmb_pkg::BYTE_W-1:0]       src_data,
  output logic                             src_packet_start_marker,
  output logic                             src_packet_end_marker,
  output logic [pmb_pkg::WORD_W-1:0]       mm_address,
  output logic                             mm_write,
  output logic                             mm_read,
  output logic [pmb_pkg::WORD_W-1:0]       mm_writedata,
  output logic [pmb_pkg::BE_W-1:0]         mm_byteenable,
  input  wire logic [pmb_pkg::WORD_W-1:0]  mm_readdata,
  input  wire logic                        mm_waitrequest
);

  // ****************************************************************
  // State
  // ****************************************************************
  pmb_state_t         state_q, state_d;
  logic [3:0]         idx_q, idx_d;
  logic [7:0]         code_q, code_d;
  logic [SIZE_W-1:0]  size_q, size_d;
  logic [WORD_W-1:0]  addr_q, addr_d;
  logic [WORD_W-1:0]  wdata_q, wdata_d;
  logic [BE_W-1:0]    be_q, be_d;
  logic [2:0]         fill_q, fill_d;
  logic               last_q, last_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [SIZE_W-1:0]  rem_q, rem_d;
  logic [2:0]         take_q, take_d;
  logic [2:0]         lane_q, lane_d;
  logic               first_q, first_d;
  logic [WORD_W-1:0]  rdata_q, rdata_d;
  logic               ready_q, write_q, read_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic              acc, is_wr, is_rd, is_inc, payload, rd_go;
  logic              wr_done, rd_done, push_ok, push_valid, buf_in_ready;
  logic [3:0]        eff_idx;
  logic [2:0]        take_now;
  logic [BYTE_W-1:0] rd_byte, resp_byte, push_data;
  logic              push_sop, push_eop;
  logic [RESP_W-1:0] buf_out;

  assign acc     = snk_valid && ready_q;
  assign is_wr   = (code_q == CODE_WR_FIX) || (code_q == CODE_WR_INC);
  assign is_rd   = (code_q == CODE_RD_FIX) || (code_q == CODE_RD_INC);
  assign is_inc  = (code_q == CODE_WR_INC) || (code_q == CODE_RD_INC);
  assign eff_idx = snk_packet_start_marker ? IDX_CODE : idx_q;
  assign payload = (eff_idx == HDR_LEN) && is_wr;
  assign rd_go   = is_rd && (eff_idx >= IDX_ADDR_LO) && (size_q != '0);
  assign wr_done = write_q && !mm_waitrequest;
  assign rd_done = read_q && !mm_waitrequest;
  assign take_now = (rem_q >= SIZE_W'(WORD_BYTES)) ? WORD_BYTES : rem_q[2:0];

  // ****************************************************************
  // Response byte selection
  // ****************************************************************
  // lane zero goes out first
  assign rd_byte   = rdata_q[BYTE_W*lane_q[1:0] +: BYTE_W];
  assign resp_byte = (lane_q == '0)          ? (code_q ^ CODE_FLIP) :
                     (lane_q == RESP_CNT_HI) ? cnt_q[23:16] :
                     (lane_q == RESP_CNT_MD) ? cnt_q[15:8] :
                     (lane_q == RESP_LAST)   ? cnt_q[7:0] : RSVD_BYTE;
  assign push_valid = (state_q == S_RDOUT) || (state_q == S_RESP);
  assign push_data  = (state_q == S_RDOUT) ? rd_byte : resp_byte;
  assign push_sop   = (state_q == S_RDOUT) ? first_q : (lane_q == '0);
  assign push_eop   = (state_q == S_RDOUT) ? ((lane_q == take_q - LANE_ONE) && (rem_q == '0))
                                           : (lane_q == RESP_LAST);
  assign push_ok    = push_valid && buf_in_ready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    code_d  = code_q;
    size_d  = size_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    be_d    = be_q;
    fill_d  = fill_q;
    last_d  = last_q;
    cnt_d   = cnt_q;
    rem_d   = rem_q;
    take_d  = take_q;
    lane_d  = lane_q;
    first_d = first_q;
    rdata_d = rdata_q;
    unique case (state_q)
      S_HDR:
      begin
        if (acc)
        begin
          idx_d = (eff_idx == HDR_LEN) ? HDR_LEN : eff_idx + IDX_ONE;
          if (eff_idx == IDX_CODE)
          begin
            code_d = snk_data;
            cnt_d  = '0;
            fill_d = '0;
          end
          if ((eff_idx == IDX_SIZE_HI) || (eff_idx == IDX_SIZE_LO))
            size_d = {size_q[7:0], snk_data};
          if ((eff_idx >= IDX_ADDR_HI) && (eff_idx <= IDX_ADDR_LO))
            addr_d = {addr_q[23:0], snk_data};
          if (snk_packet_end_marker)
            idx_d = IDX_CODE;
          if (payload)
          begin
            wdata_d[BYTE_W*fill_q[1:0] +: BYTE_W] = snk_data;
            fill_d = fill_q + LANE_ONE;
            // end marker flushes a partial word
            if ((fill_q == LANE_LAST) || snk_packet_end_marker)
            begin
              state_d = S_WR;
              be_d    = BE_W'((BE_ONE << (fill_q + LANE_ONE)) - BE_ONE);
              last_d  = snk_packet_end_marker;
            end
          end
          else if (snk_packet_end_marker)
          begin
            lane_d = '0;
            if (rd_go)
            begin
              state_d = S_RD;
              rem_d   = size_q;
              first_d = 1'b1;
            end
            else
            begin
              state_d = S_RESP;
            end
          end
        end
      end
      S_WR:
      begin
        if (wr_done)
        begin
          cnt_d  = cnt_q + CNT_W'(fill_q);
          fill_d = '0;
          lane_d = '0;
          if (code_q == CODE_WR_INC)
            addr_d = addr_q + ADDR_STEP;
          state_d = last_q ? S_RESP : S_HDR;
        end
      end
      S_RD:
      begin
        if (rd_done)
        begin
          rdata_d = mm_readdata;
          take_d  = take_now;
          rem_d   = rem_q - SIZE_W'(take_now);
          lane_d  = '0;
          state_d = S_RDOUT;
        end
      end
      S_RDOUT:
      begin
        if (push_ok)
        begin
          lane_d  = lane_q + LANE_ONE;
          first_d = 1'b0;
          if (lane_q == take_q - LANE_ONE)
          begin
            if (is_inc)
              addr_d = addr_q + ADDR_STEP;
            state_d = (rem_q == '0) ? S_HDR : S_RD;
          end
        end
      end
      S_RESP:
      begin
        if (push_ok)
        begin
          lane_d = lane_q + LANE_ONE;
          if (lane_q == RESP_LAST)
            state_d = S_HDR;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= S_HDR;
      idx_q   <= '0;
      code_q  <= CODE_IDLE;
      size_q  <= '0;
      addr_q  <= '0;
      wdata_q <= '0;
      be_q    <= '0;
      fill_q  <= '0;
      last_q  <= 1'b0;
      cnt_q   <= '0;
      rem_q   <= '0;
      take_q  <= '0;
      lane_q  <= '0;
      first_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
      code_q  <= code_d;
      size_q  <= size_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      be_q    <= be_d;
      fill_q  <= fill_d;
      last_q  <= last_d;
      cnt_q   <= cnt_d;
      rem_q   <= rem_d;
      take_q  <= take_d;
      lane_q  <= lane_d;
      first_q <= first_d;
      rdata_q <= rdata_d;
    end
  end

  // Strobes registered so every output leaves a flip-flop
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ready_q <= 1'b1;
      write_q <= 1'b0;
      read_q  <= 1'b0;
    end
    else
    begin
      ready_q <= (state_d == S_HDR);
      // one single-word write at a time
      write_q <= (state_d == S_WR);
      // read starts only with buffer room
      read_q  <= (state_d == S_RD) && (read_q || ((state_q == S_RD) && buf_in_ready));
    end
  end

  // ****************************************************************
  // Response buffer
  // ****************************************************************
  pmb_buf #(
    .WIDTH (RESP_W)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({push_sop, push_eop, push_data}),
    .out_valid (src_valid),
    .out_ready (src_ready),
    .out_data  (buf_out)
  );

  // byte symbols with framing; no error port exists
  assign src_packet_start_marker = buf_out[BYTE_W+1];
  assign src_packet_end_marker   = buf_out[BYTE_W];
  assign src_data                = buf_out[BYTE_W-1:0];
  assign snk_ready               = ready_q;
  assign mm_write                = write_q;
  assign mm_read                 = read_q;
  assign mm_address              = addr_q;
  assign mm_writedata            = wdata_q;
  assign mm_byteenable           = be_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_write_done;
    mm_write && !mm_waitrequest;
  endsequence

  sequence s_read_done;
    mm_read && !mm_waitrequest;
  endsequence

  property p_busy_not_ready;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_q != S_HDR) |-> !snk_ready;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready)
    else $error("sink ready high while busy");

  property p_wait_stalls;
    @(posedge sys_clk) disable iff (!reset_n)
      (mm_write && mm_waitrequest) |=> (mm_write && !snk_ready && $stable(mm_writedata));
  endproperty
  a_wait_stalls: assert property (p_wait_stalls)
    else $error("write dropped under wait request");

  property p_read_room;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(mm_read) |-> $past(buf_in_ready) && buf_in_ready;
  endproperty
  a_read_room: assert property (p_read_room)
    else $error("read started while source backpressured");

  property p_fix_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_write_done and (code_q == CODE_WR_FIX)) |=> $stable(mm_address);
  endproperty
  a_fix_addr: assert property (p_fix_addr)
    else $error("fixed write address moved");

  property p_inc_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      (s_write_done and (code_q == CODE_WR_INC)) |=> (mm_address == $past(mm_address) + ADDR_STEP);
  endproperty
  a_inc_addr: assert property (p_inc_addr)
    else $error("incrementing write address did not step");

  property p_read_out;
    @(posedge sys_clk) disable iff (!reset_n)
      s_read_done |=> (state_q == S_RDOUT) && (rdata_q == $past(mm_readdata));
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("completed read word not captured");

  property p_idle_no_access;
    @(posedge sys_clk) disable iff (!reset_n)
      (!is_wr && !is_rd) |-> !mm_write && !mm_read;
  endproperty
  a_idle_no_access: assert property (p_idle_no_access)
    else $error("access issued for idle code");

  property p_resp_code;
    @(posedge sys_clk) disable iff (!reset_n)
      (push_ok && (state_q == S_RESP) && (lane_q == '0)) |->
        (push_data == (code_q ^ CODE_FLIP)) && push_sop ##1 push_valid;
  endproperty
  a_resp_code: assert property (p_resp_code)
    else $error("response code byte wrong");

  property p_restart;
    @(posedge sys_clk) disable iff (!reset_n)
      (acc && snk_packet_start_marker && !snk_packet_end_marker) |=>
        (idx_q == IDX_ONE) && (cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("start marker did not restart decode");

endmodule : pmb_bridge

// File: verif/pmb_slave_model.sv
// Purpose: Word-wide memory slave answering the bridge's master port.
// Assumes: Bench drives stall; 256 words reached through address bits 9:2.
// Notes:   Read data is inverted outside read cycles so stale data never matches.
`timescale 1ns/1ps
module pmb_slave_model
  import pmb_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 stall,
  input  wire logic [WORD_W-1:0]    mm_address,
  input  wire logic                 mm_write,
  input  wire logic                 mm_read,
  input  wire logic [WORD_W-1:0]    mm_writedata,
  input  wire logic [BE_W-1:0]      mm_byteenable,
  output logic [WORD_W-1:0]         mm_readdata,
  output logic                      mm_waitrequest
);
  // ****************************************************************
  // Storage and answer
  // ****************************************************************
  logic [WORD_W-1:0] mem_q [0:255];
  wire  [7:0]        idx = mm_address[9:2];

  assign mm_waitrequest = stall;
  // Whole word, valid in completion cycle
  assign mm_readdata    = mm_read ? mem_q[idx] : ~mem_q[idx];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 256; i++)
        mem_q[i] <= '0;
    end
    else if (mm_write && !mm_waitrequest)
    begin
      for (int b = 0; b < 4; b++)
        if (mm_byteenable[b])
          mem_q[idx][8*b +: 8] <= mm_writedata[8*b +: 8];
    end
  end
endmodule : pmb_slave_model

// File: verif/test_pmb_bridge.sv
// Purpose: Self-checking bench of the packet to transaction bridge.
// Assumes: Partner slave model, random backpressure and wait states.
// Notes:   Expected response bytes are queued by the driver, popped by a monitor.
`timescale 1ns/1ps
module test_pmb_bridge;
  import pmb_pkg::*;
  logic              sys_clk, reset_n, snk_valid, snk_sop, snk_eop, src_ready, stall, hold;
  logic [7:0]        snk_data, src_data;
  logic              snk_ready, src_valid, src_sop, src_eop, mm_write, mm_read, mm_wait;
  logic [31:0]       mm_address, mm_writedata, mm_readdata;
  logic [3:0]        mm_byteenable;
  logic [31:0]       rnd_q = 32'h0000_005a;
  logic [31:0]       mem_m [0:255];
  logic [9:0]        exp_q [$];
  int                n_errors = 0;
  int                check_count = 0;

  pmb_bridge u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .snk_valid(snk_valid),
    .snk_ready(snk_ready), .snk_data(snk_data), .snk_packet_start_marker(snk_sop),
    .snk_packet_end_marker(snk_eop), .src_valid(src_valid), .src_ready(src_ready),
    .src_data(src_data), .src_packet_start_marker(src_sop), .src_packet_end_marker(src_eop),
    .mm_address(mm_address), .mm_write(mm_write), .mm_read(mm_read),
    .mm_writedata(mm_writedata), .mm_byteenable(mm_byteenable),
    .mm_readdata(mm_readdata), .mm_waitrequest(mm_wait));
  pmb_slave_model u_slave (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
    .mm_address(mm_address), .mm_write(mm_write), .mm_read(mm_read),
    .mm_writedata(mm_writedata), .mm_byteenable(mm_byteenable),
    .mm_readdata(mm_readdata), .mm_waitrequest(mm_wait));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    rnd_q = rnd_q ^ (rnd_q << 13);
    rnd_q = rnd_q ^ (rnd_q >> 17);
    rnd_q = rnd_q ^ (rnd_q << 5);
    return rnd_q;
  endfunction : xs

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Builds one command, notes its response, then streams it
  task automatic run_cmd(input logic [7:0] code, input logic [15:0] size,
                         input logic [31:0] addr, input int npay, input bit abandon);
    logic [7:0]  pkt [$];
    logic [7:0]  b;
    logic [31:0] a;
    logic [31:0] w;
    int          t;
    for (int k = 0; k < 8; k++)
    begin
      b = (k == 0) ? code : (k == 2) ? size[15:8] : (k == 3) ? size[7:0] : 8'h00;
      if (k >= 4)
        b = addr[8 * (7 - k) +: 8];
      pkt.push_back(b);
    end
    // Payload length follows size unless cut short on purpose
    for (int k = 0; k < npay; k++)
    begin
      b = 8'(xs());
      pkt.push_back(b);
      a = (code == CODE_WR_INC) ? addr + 4 * (k / 4) : addr;
      if (!abandon)
        mem_m[a[9:2]][8 * (k % 4) +: 8] = b;
    end
    if (!abandon)
    begin
      if (code == CODE_RD_INC || code == CODE_RD_FIX)
      begin
        for (int k = 0; k < size; k++)
        begin
          a = (code == CODE_RD_INC) ? addr + 4 * (k / 4) : addr;
          w = mem_m[a[9:2]];
          exp_q.push_back({k == 0, k == size - 1, w[8 * (k % 4) +: 8]});
        end
      end
      else
      begin
        exp_q.push_back({2'b10, code ^ 8'h80});
        exp_q.push_back({2'b00, 8'h00});
        exp_q.push_back({2'b00, 8'h00});
        exp_q.push_back({2'b00, 8'(npay >> 8)});
        exp_q.push_back({2'b01, 8'(npay)});
      end
    end
    foreach (pkt[i])
    begin
      snk_valid = 1'b1;
      snk_data  = pkt[i];
      snk_sop   = (i == 0);
      snk_eop   = (i == pkt.size() - 1) && !abandon;
      // Ready is a flop: its value now is what the next edge samples
      for (t = 0; t < 500 && snk_ready !== 1'b1; t++)
      begin
        @(posedge sys_clk);
        #1;
      end
      if (t >= 500)
        chk(10'(snk_ready), 10'h001);
      @(posedge sys_clk);
      #1;
    end
    snk_valid = 1'b0;
    snk_eop   = 1'b0;
    // One idle cycle so the next call never re-raises valid in this step
    @(posedge sys_clk);
    #1;
  endtask : run_cmd

  // ****************************************************************
  // Clock, random pressure, monitor, watchdog
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    logic [31:0] r;
    #1;
    r         = xs();
    src_ready = !hold && (r[0] || r[1]);
    stall     = r[2] && r[3];
  end

  // Settled mid-cycle; a transfer happens at the next rising edge
  always @(negedge sys_clk)
  begin
    if (reset_n && src_valid === 1'b1 && src_ready)
    begin
      if (exp_q.size() == 0)
        chk({src_sop, src_eop, src_data}, 10'h3ff);
      else
        chk({src_sop, src_eop, src_data}, exp_q.pop_front());
    end
  end

  initial
  begin
    #300000;
    n_errors++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] odd [3];
    odd = '{CODE_IDLE, 8'h33, 8'h01};
    for (int i = 0; i < 256; i++)
      mem_m[i] = '0;
    {snk_valid, snk_sop, snk_eop, snk_data, src_ready, stall, hold} = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    run_cmd(CODE_WR_INC, 16'h0008, 32'h0000_0100, 8, 0);
    run_cmd(CODE_RD_INC, 16'h0008, 32'h0000_0100, 0, 0);
    // Fixed write leaves second word untouched
    run_cmd(CODE_WR_FIX, 16'h0008, 32'h0000_0200, 8, 0);
    run_cmd(CODE_RD_INC, 16'h0008, 32'h0000_0200, 0, 0);
    run_cmd(CODE_RD_FIX, 16'h0008, 32'h0000_0104, 0, 0);
    // Idle and unknown codes answer with zero count
    foreach (odd[i])
      run_cmd(odd[i], 16'h0000, 32'h0000_0100, 0, 0);
    // End marker before size ends the data
    run_cmd(CODE_WR_INC, 16'h0008, 32'h0000_0300, 6, 0);
    run_cmd(CODE_RD_INC, 16'h0008, 32'h0000_0300, 0, 0);
    // New start marker drops the half-sent write
    run_cmd(CODE_WR_INC, 16'h0008, 32'h0000_0400, 2, 1);
    run_cmd(CODE_RD_INC, 16'h0004, 32'h0000_0400, 0, 0);
    // Long source stall fills the response buffer
    // Drain first, or the pending read answer would block the sink for good
    for (int t = 0; t < 3000 && exp_q.size() != 0; t++)
      @(posedge sys_clk);
    @(posedge sys_clk);
    #1 hold = 1'b1;
    run_cmd(CODE_RD_INC, 16'h0010, 32'h0000_0100, 0, 0);
    repeat (60) @(posedge sys_clk);
    #1 hold = 1'b0;
    run_cmd(CODE_WR_INC, 16'h0004, 32'h0000_0500, 4, 0);
    for (int t = 0; t < 3000 && exp_q.size() != 0; t++)
      @(posedge sys_clk);
    chk(10'(exp_q.size()), 10'h000);
    wrap_up();
  end
endmodule : test_pmb_bridge
